// ==== hdl/stepper_init_decoder.sv ====
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module stepper_init_decoder
    import stepper_init_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // Serial frame input
    input  wire logic        ser_sync,
    input  wire logic        ser_valid,
    input  wire logic        ser_bit,
    // Timing inputs
    input  wire logic        vertical_sync,
    input  wire logic        ext_osc_input,
    // Channel state from stepping logic, index 0 alpha, 1 beta
    input  wire logic [1:0]  ch_enable,
    input  wire logic [1:0]  ch_rotation,
    input  wire logic [1:0]  step_pulse_out,
    input  wire logic [1:0]  pulse_present_flag,
    input  wire logic [1:0]  pulse_gate,
    input  wire logic [1:0]  cur_sel,
    // Open-drain expander outputs
    output logic [3:0]       expander_out_o,
    output logic [3:0]       expander_out_oe,
    // Monitor and wait flags
    output logic [1:0]       monitor_pin,
    output logic             startup_wait_flag,
    output logic             combined_wait_flag,
    // Chopping
    output logic             chop_out,
    output logic             chop_int_sel,
    // Current references
    output logic [3:0]       current_reference_a,
    output logic [3:0]       current_reference_b,
    // Standard data toward the stepping logic
    output logic [63:0]      std_data,
    output logic             std_latch,
    output logic             step_inhibit,
    output logic             update_allowed
);
    frame_if fr ();

    logic [31:0] ctrl_q;
    logic [63:0] cfg_q;
    logic [63:0] std_buf_q;
    logic        std_pend_q;
    logic        init_seen_q;
    logic        chk_ok_q;
    logic        chop_en_q;
    logic        chop_q;
    logic [11:0] acc_q;
    logic        vs_prev_q;
    logic        osc_prev_q;
    logic        osc_tick;
    logic        vs_rise;
    logic        wait_done;
    logic        drive_busy;
    logic        drive_done;
    logic [2:0]  ftype;
    logic        good_init;
    logic        good_std;
    logic [4:0]  chop_code;
    logic [6:0]  chop_val;
    logic [12:0] acc_sum;
    logic [6:0]  mon_sel;
    logic        chop_mon;
    logic [1:0]  mon_d;
    logic [31:0] rdata_d;

    // Serial receiver, gated by the software enable bit
    serial_frame_rx u_rx (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .enable    (ctrl_q[0]),
        .ser_sync  (ser_sync),
        .ser_valid (ser_valid),
        .ser_bit   (ser_bit),
        .fr        (fr.rx)
    );

    // Frame classification
    assign ftype     = fr.frame[8*B_TYPE + TYPE_LSB +: 3];
    assign good_init = fr.done && fr.sum_ok && ftype == TYPE_INIT;
    assign good_std  = fr.done && fr.sum_ok && ftype == TYPE_STD;

    // Edge detectors; inputs are synchronous to clk
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vs_prev_q  <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            vs_prev_q  <= vertical_sync;
            osc_prev_q <= ext_osc_input;
        end
    end
    assign vs_rise  = vertical_sync && !vs_prev_q;
    assign osc_tick = ext_osc_input && !osc_prev_q;

    // Software control register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RST;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            ctrl_q <= {31'h0, reg_wdata[0]};
        end
    end

    // Configuration held until the next good config frame
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_q       <= CFG_RST;
            init_seen_q <= 1'b0;
        end else if (good_init) begin
            cfg_q       <= fr.frame;
            init_seen_q <= 1'b1;
        end
    end

    // Checksum status: good frame sets, bad frame clears
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chk_ok_q <= 1'b1;
        end else if (fr.done) begin
            chk_ok_q <= fr.sum_ok;
        end
    end
    assign step_inhibit = !chk_ok_q;

    // Expander pins sink on a zero bit and float on a one
    assign expander_out_o  = 4'h0;
    assign expander_out_oe = ~cfg_q[3:0];

    // Start-up wait restarts at every vertical sync rise
    wait_timer u_wait (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (osc_tick),
        .start   (vs_rise),
        .load    (cfg_q[8*B_WAIT +: 8]),
        .busy    (startup_wait_flag),
        .done    (wait_done)
    );

    // Drive wait starts as the start-up wait ends
    wait_timer u_drive (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (osc_tick),
        .start   (wait_done),
        .load    (cfg_q[8*B_DRIVE +: 8]),
        .busy    (drive_busy),
        .done    (drive_done)
    );

    // High across both waits without a gap at the hand-over
    assign combined_wait_flag = startup_wait_flag || drive_busy;

    // Data update needs both waits to be nonzero
    assign update_allowed = cfg_q[8*B_WAIT +: 8] != 8'h00 &&
                            cfg_q[8*B_DRIVE +: 8] != 8'h00;

    // A zero wait setting means the latch point never comes, so a
    // pending standard frame simply waits for a good config frame.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            std_pend_q <= 1'b0;
            std_buf_q  <= 64'h0;
        end else if (good_std) begin
            std_pend_q <= 1'b1;
            std_buf_q  <= fr.frame;
        end else if (drive_done && update_allowed) begin
            std_pend_q <= 1'b0;
        end
    end

    // Standard data latched at the end of the combined wait
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            std_data  <= 64'h0;
            std_latch <= 1'b0;
        end else begin
            std_latch <= drive_done && update_allowed && std_pend_q && chk_ok_q;
            if (drive_done && update_allowed && std_pend_q && chk_ok_q) begin
                std_data <= std_buf_q;
            end
        end
    end

    // Chopping allowed after config and the first standard latch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chop_en_q <= 1'b0;
        end else if (std_latch && init_seen_q) begin
            chop_en_q <= 1'b1;
        end
    end

    // Chopping source and code
    assign chop_int_sel = cfg_q[8*B_CHOP + CHOP_SRC_BIT];
    assign chop_code    = cfg_q[8*B_CHOP +: 5];
    assign chop_val     = {chop_code, 2'b00};
    assign acc_sum      = {1'b0, acc_q} + {6'h00, chop_val};

    // Phase accumulator on oscillator edges; toggling each time the sum
    // passes half the oscillator rate yields chop_val kHz exactly on
    // average, at the cost of one oscillator edge of jitter.
    always_ff @(posedge clk) begin
        if (sys_rst || !chop_en_q || chop_int_sel || chop_code < CHOP_MIN_CODE) begin
            acc_q  <= 12'h000;
            chop_q <= 1'b0;
        end else if (osc_tick) begin
            if (acc_sum >= {1'b0, CHOP_HALF}) begin
                acc_q  <= 12'(acc_sum - {1'b0, CHOP_HALF});
                chop_q <= !chop_q;
            end else begin
                acc_q <= acc_sum[11:0];
            end
        end
    end

    // Internal oscillator mode is handled in the analog block
    assign chop_out = chop_q && chop_en_q;
    assign chop_mon = chop_q && !chop_int_sel;

    // Monitor selection, ORed when several are chosen
    assign mon_sel = cfg_q[8*B_MON +: 7];
    always_comb begin
        mon_d[0] = (mon_sel[MON_EN]    && ch_enable[0])          ||
                   (mon_sel[MON_ROT]   && ch_rotation[0])        ||
                   (mon_sel[MON_PULSE] && step_pulse_out[0])     ||
                   (mon_sel[MON_PRES]  && pulse_present_flag[0]) ||
                   (mon_sel[MON_GATE]  && pulse_gate[0])         ||
                   (mon_sel[MON_CHK]   && chk_ok_q)              ||
                   (mon_sel[MON_CHOP]  && chop_mon);
        mon_d[1] = (mon_sel[MON_EN]    && ch_enable[1])          ||
                   (mon_sel[MON_ROT]   && ch_rotation[1])        ||
                   (mon_sel[MON_PULSE] && step_pulse_out[1])     ||
                   (mon_sel[MON_PRES]  && pulse_present_flag[1]) ||
                   (mon_sel[MON_GATE]  && pulse_gate[1])         ||
                   (mon_sel[MON_CHK]   && combined_wait_flag)    ||
                   (mon_sel[MON_CHOP]  && startup_wait_flag);
    end

    // Registered monitor pins and current references
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            monitor_pin         <= 2'b00;
            current_reference_a <= 4'h0;
            current_reference_b <= 4'h0;
        end else begin
            monitor_pin         <= mon_d;
            current_reference_a <= ref_pick(cfg_q[8*B_REFA +: 8], cur_sel[0]);
            current_reference_b <= ref_pick(cfg_q[8*B_REFB +: 8], cur_sel[1]);
        end
    end

    // Register read mux; unmapped addresses read zero
    always_comb begin
        case (reg_addr)
            REG_CTRL:   rdata_d = ctrl_q;
            REG_STATUS: rdata_d = {25'h0, chop_int_sel, chop_en_q, init_seen_q, std_pend_q,
                                   chk_ok_q, combined_wait_flag, startup_wait_flag};
            REG_CFG0:   rdata_d = cfg_q[31:0];
            REG_CFG1:   rdata_d = {8'h00, cfg_q[55:32]};
            default:    rdata_d = 32'h0;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : 32'h0;
        end
    end

    // Checks
    a_exp_levels: assert property (@(posedge clk) disable iff (sys_rst)
        good_init |=> expander_out_oe == ~$past(fr.frame[3:0]))
        else $error("expander levels not taken from config frame");

    a_wait_start: assert property (@(posedge clk) disable iff (sys_rst)
        vs_rise && cfg_q[15:8] != 8'h00 |=> startup_wait_flag)
        else $error("start-up wait did not start on vertical sync");

    a_drive_follow: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(startup_wait_flag) && !$past(vs_rise) && cfg_q[23:16] != 8'h00 |-> combined_wait_flag)
        else $error("drive wait did not follow start-up wait");

    a_bad_sum: assert property (@(posedge clk) disable iff (sys_rst)
        fr.done && !fr.sum_ok |=> step_inhibit && !std_latch)
        else $error("bad checksum did not inhibit stepping");

    a_chop_gate: assert property (@(posedge clk) disable iff (sys_rst)
        !init_seen_q |-> !chop_out)
        else $error("chopping before configuration");

    a_chop_int: assert property (@(posedge clk) disable iff (sys_rst)
        chop_int_sel && mon_sel == 7'h01 |=> !monitor_pin[0])
        else $error("chopping monitor in internal mode");

    a_mon_chk: assert property (@(posedge clk) disable iff (sys_rst)
        mon_sel == 7'h02 && fr.done && !fr.sum_ok |=> ##1 !monitor_pin[0])
        else $error("checksum monitor not low after error");

    a_cfg_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !good_init |=> $stable(cfg_q))
        else $error("config changed without good config frame");

    a_ref_pick: assert property (@(posedge clk) disable iff (sys_rst)
        cur_sel[0] |=> current_reference_a == $past(cfg_q[47:44]))
        else $error("alpha reference not taken from high nibble");
endmodule : stepper_init_decoder

// ==== include/stepper_init_pkg.sv ====
// Overview of operation
// - Byte one gives frame type and expander levels
// - Expander bit zero sinks, one floats
// - Vertical sync rise starts start-up wait
// - Byte two counts wait in 256 us steps
// - Nonzero byte two needed for data update
// - Drive wait starts when start-up wait ends
// - Byte three counts drive wait, 256 us steps
// - Nonzero byte three needed for data update
// - Byte four bit seven picks chopping source
// - Chop code times 4 kHz, below 8 off
// - Chopping waits for config and first latch
// - Byte five selects monitor sources per channel
// - Several selected monitor sources are ORed
// - Checksum monitor high, low after bad frame
// - No chopping monitor with internal oscillator
// - Wait flags and pulse flags as defined
// - Byte six holds two alpha current references
// - Byte seven holds two beta current references
// - Type 111 is config, 000 is standard
// - Frame arrives LSB first, eight bytes
// - Bytes sum to zero, else inhibit stepping
// - Current select zero low nibble, one high
package stepper_init_pkg;
    // Frame layout
    localparam int       FRAME_BYTES = 8;
    localparam int       FRAME_BITS  = 64;
    localparam int       TYPE_LSB    = 5;
    localparam logic [2:0] TYPE_INIT = 3'h7;
    localparam logic [2:0] TYPE_STD  = 3'h0;
    localparam int       B_TYPE      = 0;
    localparam int       B_WAIT      = 1;
    localparam int       B_DRIVE     = 2;
    localparam int       B_CHOP      = 3;
    localparam int       B_MON       = 4;
    localparam int       B_REFA      = 5;
    localparam int       B_REFB      = 6;
    localparam int       CHOP_SRC_BIT = 7;
    localparam logic [4:0] CHOP_MIN_CODE = 5'h08;
    // Monitor select bit positions
    localparam int       MON_EN      = 6;
    localparam int       MON_ROT     = 5;
    localparam int       MON_PULSE   = 4;
    localparam int       MON_PRES    = 3;
    localparam int       MON_GATE    = 2;
    localparam int       MON_CHK     = 1;
    localparam int       MON_CHOP    = 0;
    // Timing, counted in edges of the 4 MHz oscillator input
    localparam int       STEP_US     = 256;
    localparam int       OSC_KHZ     = 4000;
    localparam int       STEP_EDGES  = STEP_US * OSC_KHZ / 1000;
    localparam logic [9:0] STEP_LAST = 10'(STEP_EDGES - 1);
    localparam logic [11:0] CHOP_HALF = 12'(OSC_KHZ / 2);
    // Register map and reset values
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CFG0   = 8'h08;
    localparam logic [7:0] REG_CFG1   = 8'h0c;
    localparam logic [63:0] CFG_RST   = 64'h0000_0000_0000_000f;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0001;

    // Pick one of two 4-bit references by the current select bit
    function automatic logic [3:0] ref_pick(input logic [7:0] refs, input logic sel);
        ref_pick = sel ? refs[7:4] : refs[3:0];
    endfunction : ref_pick
endpackage : stepper_init_pkg

// ==== include/frame_if.sv ====
`timescale 1ns/10ps
// Received frame handed from the serial receiver to the decoder
interface frame_if;
    logic [63:0] frame;
    logic        done;
    logic        sum_ok;
    modport rx (output frame, output done, output sum_ok);
    modport cmd (input frame, input done, input sum_ok);
endinterface : frame_if

// ==== hdl/serial_frame_rx.sv ====
`timescale 1ns/10ps
module serial_frame_rx
    import stepper_init_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Serial input
    input  wire logic enable,
    input  wire logic ser_sync,
    input  wire logic ser_valid,
    input  wire logic ser_bit,
    // Frame out
    frame_if.rx       fr
);
    logic [62:0] sh_q;
    logic [5:0]  bit_q;
    logic [63:0] next_frame;
    logic [7:0]  sum;

    // New bit enters at the top, so byte 1 bit 0 ends at bit 0
    always_comb begin
        next_frame = {ser_bit, sh_q};
        sum = 8'h00;
        for (int i = 0; i < FRAME_BYTES; i++) begin
            sum = sum + next_frame[8*i +: 8];
        end
    end

    // Bit counter restarts whenever the sync frame enable drops
    always_ff @(posedge clk) begin
        if (sys_rst || !ser_sync || !enable) begin
            bit_q <= 6'h00;
        end else if (ser_valid) begin
            bit_q <= bit_q + 6'h01;
            sh_q  <= next_frame[63:1];
        end
    end

    // Frame out with checksum verdict, one-cycle done pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fr.done   <= 1'b0;
            fr.sum_ok <= 1'b1;
            fr.frame  <= 64'h0;
        end else begin
            fr.done <= ser_sync && enable && ser_valid && bit_q == 6'h3f;
            if (ser_sync && enable && ser_valid && bit_q == 6'h3f) begin
                fr.frame  <= next_frame;
                fr.sum_ok <= sum == 8'h00;
            end
        end
    end
endmodule : serial_frame_rx

// ==== hdl/wait_timer.sv ====
`timescale 1ns/10ps
module wait_timer
    import stepper_init_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       tick,
    input  wire logic       start,
    input  wire logic [7:0] load,
    // Status
    output logic            busy,
    output logic            done
);
    logic [9:0] pre_q;
    logic [7:0] cnt_q;
    logic       step;

    assign step = busy && tick && pre_q == STEP_LAST;
    // Last step of the count; also starts any following timer
    assign done = step && cnt_q == 8'h01;

    // Zero load never starts, so a zero byte blocks the cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else if (start) begin
            busy <= load != 8'h00;
        end else if (done) begin
            busy <= 1'b0;
        end
    end

    // Step counter in units of 256 us
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 8'h00;
        end else if (start) begin
            cnt_q <= load;
        end else if (step) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    // Oscillator edge prescaler
    always_ff @(posedge clk) begin
        if (sys_rst || start) begin
            pre_q <= 10'h000;
        end else if (busy && tick) begin
            pre_q <= (pre_q == STEP_LAST) ? 10'h000 : pre_q + 10'h001;
        end
    end
endmodule : wait_timer

// ==== dv/frame_host.sv ====
`timescale 1ns/10ps
module frame_host (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Frame request
    input  wire logic        go,
    input  wire logic        slow,
    input  wire logic        bad,
    input  wire logic [55:0] body,
    // Serial link
    output logic             ser_sync,
    output logic             ser_valid,
    output logic             ser_bit,
    output logic             busy
);
    logic [63:0] frame_q;
    logic [5:0]  idx_q;
    logic        gap_q;
    logic [7:0]  fix;

    // Last byte makes the byte sum zero; bad breaks it
    always_comb begin
        fix = 8'h00;
        for (int i = 0; i < 7; i++) begin
            fix = fix - body[8*i +: 8];
        end
    end

    // One bit a cycle, or every other cycle in slow mode
    always_ff @(posedge clk) begin
        ser_valid <= 1'b0;
        ser_sync  <= busy;
        gap_q     <= busy && slow && !gap_q;
        if (sys_rst) begin
            busy    <= 1'b0;
            ser_bit <= 1'b0;
        end else if (busy && !(slow && !gap_q)) begin
            ser_valid <= 1'b1;
            ser_bit   <= frame_q[idx_q];
            idx_q     <= idx_q + 6'h01;
            busy      <= idx_q != 6'h3f;
        end else if (go && !busy) begin
            frame_q <= {fix ^ {7'h00, bad}, body};
            idx_q   <= 6'h00;
            busy    <= 1'b1;
        end else if (!busy) begin
            ser_bit <= ~ser_bit; // Idle line flickers so a stale bit is never reused
        end
    end
endmodule : frame_host

// ==== dv/stepper_init_frame_decoder_tb.sv ====
`timescale 1ns/10ps
module stepper_init_frame_decoder_tb
    import stepper_init_pkg::*;
;
    logic        clk, sys_rst, reg_wr, reg_rd, vsync, osc, go, slow, bad, busy, chop, isel, slat, inh, upd;
    logic        ser_sync, ser_valid, ser_bit, sflag, cflag;
    logic [1:0]  csel, mon, s;
    logic [3:0]  exp_o, exp_oe, ref_a, ref_b;
    logic [7:0]  reg_addr;
    logic [9:0]  src;
    logic [31:0] reg_wdata, reg_rdata;
    logic [55:0] body, good, sbody;
    logic [63:0] std_q;
    int          fails, samples_checked, n, m;
    time         t0;

    stepper_init_decoder dut (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ser_sync(ser_sync), .ser_valid(ser_valid), .ser_bit(ser_bit),
        .vertical_sync(vsync), .ext_osc_input(osc), .ch_enable(src[9:8]), .ch_rotation(src[7:6]),
        .step_pulse_out(src[5:4]), .pulse_present_flag(src[3:2]), .pulse_gate(src[1:0]), .cur_sel(csel),
        .expander_out_o(exp_o), .expander_out_oe(exp_oe), .monitor_pin(mon), .startup_wait_flag(sflag),
        .combined_wait_flag(cflag), .chop_out(chop), .chop_int_sel(isel), .current_reference_a(ref_a),
        .current_reference_b(ref_b), .std_data(std_q), .std_latch(slat), .step_inhibit(inh), .update_allowed(upd)
    );

    frame_host host (
        .clk(clk), .sys_rst(sys_rst), .go(go), .slow(slow), .bad(bad), .body(body),
        .ser_sync(ser_sync), .ser_valid(ser_valid), .ser_bit(ser_bit), .busy(busy)
    );

    // Bench clock, 40 ns
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Oscillator at half the clock: one tick per two cycles keeps waits short
    always @(posedge clk) osc <= ~osc;

    task automatic chk(input logic [63:0] got, input logic [63:0] want);
        samples_checked++;
        if (got !== want) begin
            fails++;
            $display("Error %0t: got %h want %h", $time, got, want);
        end
    endtask : chk

    function automatic logic near(input time d, input int want);
        return d / 40 + 6 >= want && d / 40 <= want + 6;
    endfunction : near

    task automatic test_done;
        if (fails == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic limit(input int cnt, input int max);
        if (cnt >= max) begin
            fails++;
            $display("Error %0t: timeout", $time);
            test_done();
        end
    endtask : limit

    function automatic logic [55:0] cfg(input logic [3:0] ex, input logic [7:0] w, d, ch, mo, ra, rb);
        return {rb, ra, 1'b0, mo[6:0], ch & 8'h9f, d, w, 4'he, ex};
    endfunction : cfg

    // Whole frame through the host model, then let config settle
    task automatic send(input logic [55:0] b, input logic bd);
        body <= b;
        bad <= bd;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (n = 0; n < 200 && busy !== 1'b0; n++) @(posedge clk);
        limit(n, 200);
        repeat (4) @(posedge clk);
    endtask : send

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk(reg_rdata, want);
    endtask : rd

    // Chopping wave and alpha monitor over 600 cycles
    task automatic watch(output logic [1:0] seen);
        seen = 2'b00;
        repeat (600) begin
            @(posedge clk);
            if (chop !== 1'b0) seen[1] = 1'b1;
            if (mon[0] !== 1'b0) seen[0] = 1'b1;
        end
    endtask : watch

    task automatic t_reset;
        @(posedge clk);
        chk(exp_oe, 4'h0);
        chk({mon, sflag, cflag, chop, inh, upd}, 7'h00);
        rd(REG_CTRL, CTRL_RST);
        rd(8'h30, 32'h0);
    endtask : t_reset

    task automatic t_decode;
        send(good, 1'b0);
        chk(exp_oe, 4'ha);
        chk(exp_o, 4'h0);
        chk(mon, 2'b01);
        rd(REG_CFG0, 32'h0802_01e5);
        rd(REG_CFG1, 32'h00d7_3c02);
        for (int i = 0; i < 4; i++) begin
            csel <= 2'(i);
            repeat (2) @(posedge clk);
            chk(ref_a, i[0] ? 4'h3 : 4'hc);
            chk(ref_b, i[1] ? 4'hd : 4'h7);
        end
    endtask : t_decode

    task automatic t_badsum;
        send(cfg(4'h3, 8'h05, 8'h06, 8'h10, 8'h00, 8'h00, 8'hff), 1'b1);
        chk(exp_oe, 4'ha);
        chk(inh, 1'b1);
        chk(mon, 2'b00);
        wr(REG_CFG0, 32'hffff_ffff);
        wr(REG_CTRL, 32'h0);
        send(cfg(4'h3, 8'h05, 8'h06, 8'h10, 8'h00, 8'h00, 8'hff), 1'b0);
        chk(exp_oe, 4'ha);
        rd(REG_CFG0, 32'h0802_01e5);
        wr(REG_CTRL, 32'h1);
        send(good, 1'b0);
        chk(mon, 2'b01);
    endtask : t_badsum

    // Each shared source alone, others held at the opposite pattern
    task automatic t_monitor;
        logic [9:0] v;
        for (int k = 2; k < 7; k++) begin
            v = 10'h155;
            v[(k-2)*2 +: 2] = 2'b10;
            src <= v;
            send(cfg(4'h5, 8'h01, 8'h02, 8'h08, 8'h01 << k, 8'h3c, 8'hd7), 1'b0);
            chk(mon, 2'b10);
        end
        src <= 10'h201;
        send(cfg(4'h5, 8'h01, 8'h02, 8'h08, 8'h7c, 8'h3c, 8'hd7), 1'b0);
        chk(mon, 2'b11);
    endtask : t_monitor

    // Waits count 1024 ticks per step, two cycles per tick
    task automatic t_waits;
        send(cfg(4'h5, 8'h01, 8'h02, 8'h08, 8'h03, 8'h3c, 8'hd7), 1'b0);
        vsync <= 1'b1;
        t0 = $time;
        repeat (3) @(posedge clk);
        chk(sflag, 1'b1);
        @(posedge clk);
        chk(mon, 2'b11);
        slow <= 1'b1;
        send(sbody, 1'b0);
        slow <= 1'b0;
        for (n = 0; n < 2200 && sflag !== 1'b0; n++) @(posedge clk);
        limit(n, 2200);
        chk(near($time - t0, 2051), 1'b1);
        chk(cflag, 1'b1);
        t0 = $time;
        m = 0;
        for (n = 0; n < 4200 && cflag !== 1'b0; n++) begin
            @(posedge clk);
            if (chop !== 1'b0) m = 1;
        end
        limit(n, 4200);
        chk(near($time - t0, 4096), 1'b1);
        chk(m, 0);
        for (n = 0; n < 8 && slat !== 1'b1; n++) @(posedge clk);
        limit(n, 8);
        @(posedge clk);
        chk(std_q[55:0], sbody);
        for (n = 0; n < 600 && chop !== 1'b1; n++) @(posedge clk);
        t0 = $time;
        for (n = 0; n < 600 && chop !== 1'b0; n++) @(posedge clk);
        for (n = 0; n < 600 && chop !== 1'b1; n++) @(posedge clk);
        limit(n, 600);
        chk(near($time - t0, 250), 1'b1);
        vsync <= 1'b0;
    endtask : t_waits

    task automatic t_chop;
        send(cfg(4'h5, 8'h01, 8'h02, 8'h9f, 8'h01, 8'h3c, 8'hd7), 1'b0);
        chk(isel, 1'b1);
        watch(s);
        chk(s[0], 1'b0);
        send(cfg(4'h5, 8'h01, 8'h02, 8'h07, 8'h01, 8'h3c, 8'hd7), 1'b0);
        chk(isel, 1'b0);
        watch(s);
        chk(s, 2'b00);
    endtask : t_chop

    task automatic t_zero;
        send(cfg(4'h5, 8'h00, 8'h02, 8'h08, 8'h03, 8'h3c, 8'hd7), 1'b0);
        chk(upd, 1'b0);
        vsync <= 1'b1;
        repeat (4) @(posedge clk);
        chk(sflag, 1'b0);
        vsync <= 1'b0;
        send(cfg(4'h5, 8'h01, 8'h00, 8'h08, 8'h03, 8'h3c, 8'hd7), 1'b0);
        chk(upd, 1'b0);
        send(good, 1'b0);
        chk(upd, 1'b1);
    endtask : t_zero

    // Reset for four cycles, then each scenario in turn
    initial begin
        {sys_rst, reg_wr, reg_rd, vsync, osc, go, slow, bad} = 8'h80;
        {reg_addr, reg_wdata, body, src, csel} = '0;
        fails = 0;
        samples_checked = 0;
        good = cfg(4'h5, 8'h01, 8'h02, 8'h08, 8'h02, 8'h3c, 8'hd7);
        sbody = 56'h12_3456_789a_bc03;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_decode();
        t_badsum();
        t_monitor();
        t_waits();
        t_chop();
        t_zero();
        test_done();
    end
endmodule : stepper_init_frame_decoder_tb
